/* core/hps_regs.svh */
// register map, field positions, reset values and timing constants
`ifndef HPS_REGS_SVH
`define HPS_REGS_SVH
`define HPS_CTRL_OFS 8'h00
`define HPS_PWIDTH_OFS 8'h04
`define HPS_PINCFG_OFS 8'h08
`define HPS_STAT_OFS 8'h0C
`define HPS_CTRL_ON_EN 0
`define HPS_CTRL_OFF_EN 1
`define HPS_CTRL_RST_EN 2
`define HPS_CTRL_BLANK_EN 3
`define HPS_CTRL_PINV 4
`define HPS_CTRL_RINV 5
`define HPS_CTRL_RST 32'h0000_0000
`define HPS_PINCFG_RST 32'h0000_0223
`define HPS_CLK_HZ 100000000
`define HPS_ON_HOLD_MS 250
`define HPS_LONG_HOLD_MS 4000
`define HPS_PWIDTH_MS 1000
`define HPS_EXTRA_MS 5000
`define HPS_RST_MS 1000
`define HPS_MS_CYC (`HPS_CLK_HZ / 1000)
`endif

/* core/hps_pkg.sv */
// types of the host power switch controller
package hps_pkg;
  typedef enum logic [4:0] {
    HPS_IDLE = 5'b00001,
    HPS_PWR = 5'b00010,
    HPS_HOLD = 5'b00100,
    HPS_RST = 5'b01000,
    HPS_SELF = 5'b10000
  } hps_state_e;
  typedef logic [31:0] hps_word_t;
endpackage

/* core/hps_tick.sv */
// millisecond tick generator
`timescale 1ns/100ps
`default_nettype none
`include "hps_regs.svh"
module hps_tick import hps_pkg::*; #(
  parameter int unsigned MS_CYC = `HPS_MS_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } hps_tick_s;
  hps_tick_s s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= MS_CYC - 1) begin
      s_d.cnt = 32'h0000_0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick & ce;
endmodule // hps_tick
`default_nettype wire

/* core/hps_hold.sv */
// key hold timer in milliseconds, cleared on release
`timescale 1ns/100ps
`default_nettype none
module hps_hold import hps_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic key,
  output logic [15:0] ms
);
  typedef struct packed {
    logic [15:0] ms;
  } hps_hold_s;
  hps_hold_s s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (!key) begin
      s_d.ms = 16'h0000; // RQ15
    end else if (tick && s_q.ms != 16'hFFFF) begin
      s_d.ms = s_q.ms + 16'h0001;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  assign ms = s_q.ms;
endmodule // hps_hold
`default_nettype wire

/* core/hps_ctrl.sv */
// host power switch controller top with AXI4-Lite registers
// Operation
// (RQ1) power switch pin is released except while pulsing; level per invert bit
// (RQ2) reset pin is released except while resetting the host
// (RQ3) power on, hard off and hard reset each need their own enable bit
// (RQ4) sense low, enter held 250 ms: pulse power switch for set width
// (RQ5) sense high, cancel held 4 s: pulse power switch, at least width
// (RQ6) cancel still held after width: keep driving up to 5 s more
// (RQ7) sense high, enter held 4 s: drive reset pin for 1 s
// (RQ8) after keypad host reset the block restarts itself
// (RQ9) when enabled, blank display while sense is low
// (RQ10) host leaves power, reset and sense pins in default modes
// (RQ11) sense pin mode code 011, user flag 0
// (RQ12) switch and reset pins mode code 010, user flag 0
// (RQ13) host sets pin modes via command 34 with three bytes
// (RQ14) host stores pin modes as power-up default
// (RQ15) hold timers clear on release; early release gives no pulse
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "hps_regs.svh"
module hps_ctrl import hps_pkg::*; #(
  parameter int unsigned MS_CYC = `HPS_MS_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic key_enter,
  input wire logic key_cancel,
  input wire logic supply_sense_function,
  output logic pwr_sw_o,
  output logic pwr_sw_oe,
  output logic host_rst_o,
  output logic host_rst_oe,
  output logic display_blank,
  output logic self_restart,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================
  // state
  typedef struct packed {
    hps_state_e st;
    logic [15:0] ms;
    logic pwr_drv;
    logic rst_drv;
    logic self_rst;
    logic blank;
    hps_word_t ctrl;
    logic [15:0] pwidth;
    hps_word_t pincfg;
    logic aw_ok;
    logic [7:0] awaddr;
    logic w_ok;
    hps_word_t wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    hps_word_t rdata;
    logic [1:0] rresp;
  } hps_ctrl_s;
  hps_ctrl_s s_q, s_d;
  logic tick;
  logic [15:0] enter_ms, cancel_ms;

  function automatic hps_word_t merge(hps_word_t o, hps_word_t n,
                                      logic [3:0] be);
    hps_word_t r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic known(logic [7:0] a);
    return a == `HPS_CTRL_OFS || a == `HPS_PWIDTH_OFS ||
           a == `HPS_PINCFG_OFS || a == `HPS_STAT_OFS;
  endfunction

  // ==========================================================
  // submodules
  hps_tick #(.MS_CYC(MS_CYC)) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick)
  );
  hps_hold u_enter (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick),
    .key(key_enter),
    .ms(enter_ms)
  );
  hps_hold u_cancel (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick),
    .key(key_cancel),
    .ms(cancel_ms)
  );

  // ==========================================================
  // next state
  logic pins_ok;
  always_comb begin
    s_d = s_q;
    // pin modes must be default for the power functions to act
    pins_ok = (s_q.pincfg == `HPS_PINCFG_RST); // RQ10 RQ11 RQ12
    s_d.blank = s_q.ctrl[`HPS_CTRL_BLANK_EN] & ~supply_sense_function; // RQ9
    if (tick) s_d.ms = s_q.ms + 16'h0001;
    case (s_q.st)
      HPS_IDLE: begin
        s_d.ms = 16'h0000;
        if (pins_ok && !supply_sense_function &&
            s_q.ctrl[`HPS_CTRL_ON_EN] &&
            enter_ms >= 16'(`HPS_ON_HOLD_MS)) begin // RQ3 RQ4
          s_d.st = HPS_PWR;
          s_d.pwr_drv = 1'b1;
        end else if (pins_ok && supply_sense_function &&
                     s_q.ctrl[`HPS_CTRL_OFF_EN] &&
                     cancel_ms >= 16'(`HPS_LONG_HOLD_MS)) begin // RQ3 RQ5
          s_d.st = HPS_HOLD;
          s_d.pwr_drv = 1'b1;
        end else if (pins_ok && supply_sense_function &&
                     s_q.ctrl[`HPS_CTRL_RST_EN] &&
                     enter_ms >= 16'(`HPS_LONG_HOLD_MS)) begin // RQ3 RQ7
          s_d.st = HPS_RST;
          s_d.rst_drv = 1'b1;
        end
      end
      HPS_PWR: begin
        if (s_q.ms >= s_q.pwidth) begin // RQ4
          s_d.st = HPS_IDLE;
          s_d.pwr_drv = 1'b0;
        end
      end
      HPS_HOLD: begin
        if (s_q.ms >= s_q.pwidth &&
            (!key_cancel ||
             s_q.ms >= s_q.pwidth + 16'(`HPS_EXTRA_MS))) begin // RQ5 RQ6
          s_d.st = HPS_IDLE;
          s_d.pwr_drv = 1'b0;
        end
      end
      HPS_RST: begin
        if (s_q.ms >= 16'(`HPS_RST_MS)) begin // RQ7
          s_d.st = HPS_SELF;
          s_d.rst_drv = 1'b0;
          s_d.self_rst = 1'b1; // RQ8
        end
      end
      HPS_SELF: begin
        s_d.st = HPS_IDLE;
      end
      default: begin
        s_d.st = HPS_IDLE;
        s_d.pwr_drv = 1'b0;
        s_d.rst_drv = 1'b0;
      end
    endcase

    // ---------------- AXI4-Lite write
    if (s_axi_awvalid && !s_q.aw_ok) begin
      s_d.aw_ok = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_ok) begin
      s_d.w_ok = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = known(s_q.awaddr) ? 2'b00 : 2'b10;
      case (s_q.awaddr)
        `HPS_CTRL_OFS: begin
          s_d.ctrl = merge(s_q.ctrl, s_q.wdata, s_q.wstrb) &
                     32'h0000_003F;
        end
        `HPS_PWIDTH_OFS: begin
          s_d.pwidth = 16'(merge({16'h0000, s_q.pwidth}, s_q.wdata,
                                 s_q.wstrb));
        end
        `HPS_PINCFG_OFS: begin
          s_d.pincfg = merge(s_q.pincfg, s_q.wdata, s_q.wstrb) &
                       32'h0000_0FFF;
        end
        default: begin
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;

    // ---------------- AXI4-Lite read
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = known(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        `HPS_CTRL_OFS: s_d.rdata = s_q.ctrl;
        `HPS_PWIDTH_OFS: s_d.rdata = {16'h0000, s_q.pwidth};
        `HPS_PINCFG_OFS: s_d.rdata = s_q.pincfg;
        `HPS_STAT_OFS: s_d.rdata = {23'h00_0000, s_q.st,
                                    supply_sense_function, s_q.blank,
                                    s_q.rst_drv, s_q.pwr_drv};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk) begin
    if (!rst_n || (ce && s_q.self_rst)) begin // RQ8
      s_q.st <= HPS_IDLE;
      s_q.ms <= 16'h0000;
      s_q.pwr_drv <= 1'b0;
      s_q.rst_drv <= 1'b0;
      s_q.self_rst <= 1'b0;
      s_q.blank <= 1'b0;
      s_q.aw_ok <= 1'b0;
      s_q.awaddr <= 8'h00;
      s_q.w_ok <= 1'b0;
      s_q.wdata <= 32'h0000_0000;
      s_q.wstrb <= 4'h0;
      s_q.bvalid <= 1'b0;
      s_q.bresp <= 2'b00;
      s_q.rvalid <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.rresp <= 2'b00;
      if (!rst_n) begin
        s_q.ctrl <= `HPS_CTRL_RST;
        s_q.pwidth <= 16'(`HPS_PWIDTH_MS);
        s_q.pincfg <= `HPS_PINCFG_RST;
      end
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign pwr_sw_oe = s_q.pwr_drv; // RQ1
  assign pwr_sw_o = s_q.pwr_drv & s_q.ctrl[`HPS_CTRL_PINV]; // RQ1
  assign host_rst_oe = s_q.rst_drv; // RQ2
  assign host_rst_o = s_q.rst_drv & s_q.ctrl[`HPS_CTRL_RINV]; // RQ2
  assign display_blank = s_q.blank;
  assign self_restart = s_q.self_rst;
  assign s_axi_awready = ~s_q.aw_ok;
  assign s_axi_wready = ~s_q.w_ok;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = ~s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // ==========================================================
  // assertions
  pwr_idle_off_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
    s_q.st == HPS_IDLE |-> !pwr_sw_oe && !host_rst_oe)
    else $error("pins driven while idle");
  rst_pin_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
    host_rst_oe |-> s_q.st == HPS_RST)
    else $error("reset pin driven outside reset");
  enable_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
    s_q.st == HPS_IDLE && $past(s_q.st) == HPS_IDLE && s_d.st == HPS_PWR
    |-> s_q.ctrl[`HPS_CTRL_ON_EN])
    else $error("power on without enable");
  on_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ4
    ce && s_q.st == HPS_IDLE && s_d.st == HPS_PWR
    |-> enter_ms >= 16'(`HPS_ON_HOLD_MS) && !supply_sense_function)
    else $error("power on too early");
  off_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ5
    ce && s_q.st == HPS_IDLE && s_d.st == HPS_HOLD
    |-> cancel_ms >= 16'(`HPS_LONG_HOLD_MS) && supply_sense_function)
    else $error("hard off too early");
  off_max_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ6
    s_q.st == HPS_HOLD
    |-> s_q.ms <= s_q.pwidth + 16'(`HPS_EXTRA_MS) + 16'h0001)
    else $error("hard off too long");
  rst_len_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ7
    s_q.st == HPS_RST |-> s_q.ms <= 16'(`HPS_RST_MS))
    else $error("host reset too long");
  self_rst_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ8
    ce && s_q.self_rst |=> !pwr_sw_oe && s_q.st == HPS_IDLE)
    else $error("no restart after reset");
  blank_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ9
    ce && s_q.ctrl[`HPS_CTRL_BLANK_EN] && !supply_sense_function
    |=> display_blank || $past(s_q.self_rst))
    else $error("display not blanked");
endmodule // hps_ctrl
`default_nettype wire

/* testbench/hps_host_model.sv */
// motherboard power and reset switch inputs driven by the controller
`timescale 1ns/100ps
`default_nettype none
module hps_host_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pwr_sw_o,
  input wire logic pwr_sw_oe,
  input wire logic host_rst_o,
  input wire logic host_rst_oe,
  output logic sense,
  output logic pwr_line,
  output logic rst_line,
  output logic [7:0] pwr_presses,
  output logic [7:0] rst_presses
);
  logic pwr_prev;
  logic rst_prev;
  // released inputs float to the board pull-up
  assign pwr_line = pwr_sw_oe ? pwr_sw_o : 1'b1;
  assign rst_line = host_rst_oe ? host_rst_o : 1'b1;
  // sense rail: pulled up while host on, driven low while off
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sense <= 1'b0;
      pwr_prev <= 1'b1;
      rst_prev <= 1'b1;
      pwr_presses <= 8'h00;
      rst_presses <= 8'h00;
    end else begin
      pwr_prev <= pwr_line;
      rst_prev <= rst_line;
      if (pwr_line && !pwr_prev) begin
        sense <= !sense;
        pwr_presses <= pwr_presses + 8'h01;
      end
      if (rst_line && !rst_prev) begin
        rst_presses <= rst_presses + 8'h01;
      end
    end
  end
endmodule // hps_host_model
`default_nettype wire

/* testbench/host_power_switch_control_tb_top.sv */
// self-checking bench of the host power switch controller
`timescale 1ns/100ps
`default_nettype none
`include "hps_regs.svh"
module host_power_switch_control_tb_top;
  import hps_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic key_enter = 1'b0;
  logic key_cancel = 1'b0;
  logic sense, pwr_o, pwr_oe, rst_o, rst_oe, blank, selfr;
  logic pwr_line, rst_line;
  logic [7:0] npwr, nrst;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  hps_word_t rdata;
  int fail_count = 0;
  int total_checks = 0;
  int pw = 0;
  int rw = 0;
  int i;
  logic [31:0] seed = 32'h0000_389E;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int pq[$];
  localparam int MSC = 8;
  logic ce = 1'b1;
  logic [3:0] ws = 4'hF;
  logic [31:0] ctrl_x = 32'h0000_0000;
  logic [1:0] be_x;
  logic [33:0] re_x;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
  always #5 mclk = ~mclk;
  hps_ctrl #(.MS_CYC(MSC)) u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .key_enter(key_enter), .key_cancel(key_cancel),
    .supply_sense_function(sense), .pwr_sw_o(pwr_o), .pwr_sw_oe(pwr_oe),
    .host_rst_o(rst_o), .host_rst_oe(rst_oe), .display_blank(blank),
    .self_restart(selfr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  hps_host_model u_host (.mclk(mclk), .rst_n(rst_n), .pwr_sw_o(pwr_o),
    .pwr_sw_oe(pwr_oe), .host_rst_o(rst_o), .host_rst_oe(rst_oe),
    .sense(sense), .pwr_line(pwr_line), .rst_line(rst_line),
    .pwr_presses(npwr), .rst_presses(nrst));
  // ==========
  // bus and key tasks
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    bq.push_back(e);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= ws;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    rq.push_back({e, d});
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic ms(input int n);
    repeat (n * MSC) @(posedge mclk);
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========
  // result watcher
  always @(posedge mclk) begin
    if (bvalid && bready) begin
      be_x = bq.pop_front();
      `CHK(bresp, be_x)
    end
    if (rvalid && rready) begin
      re_x = rq.pop_front();
      `CHK({rresp, rdata}, re_x)
    end
    if (pwr_oe) begin
      pw++;
      `CHK(pwr_o, ctrl_x[`HPS_CTRL_PINV])
    end else if (pw > 0) begin
      `CHK(pq.size() > 1 && pw >= pq[0] && pw <= pq[1], 1'b1)
      if (pq.size() > 1) void'(pq.pop_front());
      if (pq.size() > 0) void'(pq.pop_front());
      pw = 0;
    end
    if (rst_oe) begin
      rw++;
      `CHK(rst_o, ctrl_x[`HPS_CTRL_RINV])
    end else if (rw > 0) begin
      `CHK(pq.size() > 1 && rw >= pq[0] && rw <= pq[1], 1'b1)
      if (pq.size() > 1) void'(pq.pop_front());
      if (pq.size() > 0) void'(pq.pop_front());
      rw = 0;
    end
  end
  initial begin
    repeat (95000) @(posedge mclk);
    fail_count++;
    give_verdict();
  end
  // ==========
  // scenarios
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`HPS_CTRL_OFS, 32'h0000_0000, 2'b00);
    rd(`HPS_PWIDTH_OFS, 32'h0000_03E8, 2'b00);
    rd(`HPS_PINCFG_OFS, 32'h0000_0223, 2'b00);
    wr(8'h10, xs(), 2'b10);
    rd(8'h10, 32'h0000_0000, 2'b10);
    ws = 4'h1;
    wr(`HPS_PWIDTH_OFS, 32'hFFFF_FF14, 2'b00);
    rd(`HPS_PWIDTH_OFS, 32'h0000_0314, 2'b00);
    ws = 4'hF;
    wr(`HPS_PWIDTH_OFS, 32'h0000_0014, 2'b00);
    rd(`HPS_PWIDTH_OFS, 32'h0000_0014, 2'b00);
    key_enter <= 1'b1;
    ms(300);
    key_enter <= 1'b0;
    ctrl_x = 32'h0000_0009;
    wr(`HPS_CTRL_OFS, ctrl_x, 2'b00);
    ms(1);
    `CHK(blank, 1'b1)
    wr(`HPS_PINCFG_OFS, 32'h0000_0222, 2'b00);
    key_enter <= 1'b1;
    ms(260);
    key_enter <= 1'b0;
    wr(`HPS_PINCFG_OFS, 32'h0000_0223, 2'b00);
    key_enter <= 1'b1;
    ms(100 + int'(xs() % 140));
    key_enter <= 1'b0;
    ms(5);
    `CHK(npwr, 8'h00)
    pq.push_back(195);
    pq.push_back(215);
    key_enter <= 1'b1;
    for (i = 0; i < 3000 && !pwr_oe; i++) @(posedge mclk);
    `CHK(i >= 1980 && i <= 2030, 1'b1)
    key_enter <= 1'b0;
    ce <= 1'b0;
    repeat (40) @(posedge mclk);
    ce <= 1'b1;
    ms(30);
    `CHK({npwr, sense, blank}, 10'h006)
    ctrl_x = 32'h0000_000E;
    wr(`HPS_CTRL_OFS, ctrl_x, 2'b00);
    pq.push_back(7950);
    pq.push_back(8030);
    key_enter <= 1'b1;
    for (i = 0; i < 33000 && !rst_oe; i++) @(posedge mclk);
    `CHK(i >= 31980 && i <= 32030, 1'b1)
    key_enter <= 1'b0;
    for (i = 0; i < 8100 && !selfr; i++) @(posedge mclk);
    `CHK({i >= 7950, selfr, rst_oe}, 3'b110)
    rd(`HPS_CTRL_OFS, 32'h0000_000E, 2'b00);
    `CHK(nrst, 8'h01)
    pq.push_back(235);
    pq.push_back(270);
    key_cancel <= 1'b1;
    for (i = 0; i < 33000 && !pwr_oe; i++) @(posedge mclk);
    `CHK(i >= 31980 && i <= 32030, 1'b1)
    ms(30);
    key_cancel <= 1'b0;
    ms(2);
    `CHK({sense, blank, pwr_oe}, 3'b010)
    ctrl_x = 32'h0000_0039;
    wr(`HPS_CTRL_OFS, ctrl_x, 2'b00);
    pq.push_back(155);
    pq.push_back(175);
    key_enter <= 1'b1;
    for (i = 0; i < 3000 && !pwr_oe; i++) @(posedge mclk);
    `CHK(i >= 1980 && i <= 2030, 1'b1)
    key_enter <= 1'b0;
    ms(30);
    `CHK({npwr, sense, pwr_oe}, 10'h008)
    ms(1);
    give_verdict();
  end
endmodule // host_power_switch_control_tb_top
`default_nettype wire
